// File: rtl/serial_port_regs_pkg.sv
/*
 * Constants, register map and state types for the serial port
 * interrupt, DMA and data-window register block.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package serial_port_regs_pkg;

    // ****************************************************
    // Register byte offsets
    // ****************************************************
    localparam logic [7:0] OFF_IRQ_EN = 8'h2c;
    localparam logic [7:0] OFF_MASKED = 8'h30;
    localparam logic [7:0] OFF_RAW = 8'h34;
    localparam logic [7:0] OFF_TXO_CLR = 8'h38;
    localparam logic [7:0] OFF_RXO_CLR = 8'h3c;
    localparam logic [7:0] OFF_RXU_CLR = 8'h40;
    localparam logic [7:0] OFF_CONT_CLR = 8'h44;
    localparam logic [7:0] OFF_ALL_CLR = 8'h48;
    localparam logic [7:0] OFF_DMA_GATE = 8'h4c;
    localparam logic [7:0] OFF_TX_DMA_LVL = 8'h50;
    localparam logic [7:0] OFF_RX_DMA_LVL = 8'h54;
    localparam logic [7:0] OFF_IDENTITY = 8'h58;
    localparam logic [7:0] OFF_REVISION = 8'h5c;
    localparam logic [7:0] OFF_DATA_LO = 8'h60;
    localparam logic [7:0] OFF_DATA_HI = 8'h9c;
    localparam logic [7:0] OFF_IRQ_CLR = 8'ha0;
    localparam logic [7:0] OFF_SPARE_A = 8'hf4;
    localparam logic [7:0] OFF_SPARE_B = 8'hf8;
    localparam logic [7:0] OFF_SAMPLE_DLY = 8'hfc;

    // ****************************************************
    // Field positions, widths and reset values
    // ****************************************************
    localparam int BIT_TX_EMPTY = 0;
    localparam int BIT_TX_OVF = 1;
    localparam int BIT_RX_UND = 2;
    localparam int BIT_RX_OVF = 3;
    localparam int BIT_RX_FULL = 4;
    localparam int BIT_CONT = 5;
    localparam int BIT_RX_GATE = 0;
    localparam int BIT_TX_GATE = 1;
    localparam int FLAG_W = 6;
    localparam int LVL_W = 3;
    localparam int DLY_W = 8;
    localparam int DATA_W = 16;
    localparam logic [5:0] STICKY_MASK = 6'h2e;
    localparam logic [5:0] IRQ_EN_RST = 6'h00;
    localparam logic [2:0] LVL_RST = 3'h0;
    localparam logic [7:0] DLY_RST = 8'h00;
    localparam logic [31:0] SPARE_RST = 32'h0000_0000;

    // ****************************************************
    // Types
    // ****************************************************
    typedef enum logic {smp_idle, smp_wait} smp_state_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } tx_push_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [FLAG_W-1:0] sticky;
        logic [FLAG_W-1:0] irq_en;
        logic irq;
        logic [1:0] dma_gate;
        logic [LVL_W-1:0] tx_dma_lvl;
        logic [LVL_W-1:0] rx_dma_lvl;
        logic tx_dma_req;
        logic rx_dma_req;
        logic [31:0] spare_a;
        logic [31:0] spare_b;
        logic [DLY_W-1:0] dly;
        tx_push_t push;
        logic rx_pop;
        logic [1:0] sclk_sync;
        logic sclk_prev;
        logic [1:0] rxd_sync;
        logic [1:0] cont_sync;
        smp_state_t smp_st;
        logic [DLY_W-1:0] smp_cnt;
        logic smp_bit;
        logic smp_valid;
    } regs_state_t;

endpackage : serial_port_regs_pkg

// File: rtl/serial_port_irq_dma_regs.sv
/*
 * Interrupt flags, read-to-clear registers, DMA request gating,
 * FIFO data window and receive sample delay of a serial port.
 * Assumes external FIFOs with head data valid while not empty, framing
 * logic on clk_i, and async pins for link clock, rxd and contention.
 */
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module serial_port_irq_dma_regs #(
    parameter int FIFO_LVL_W = 4,
    parameter logic [31:0] IDENTITY_VALUE = 32'h0000_5a01, // Arbitrary value
    parameter logic [31:0] REVISION_VALUE = 32'h0000_0100 // Arbitrary value
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Transmit FIFO side
    output serial_port_regs_pkg::tx_push_t tx_push_o,
    input wire logic tx_full_i,
    input wire logic [FIFO_LVL_W-1:0] tx_level_i,
    input wire logic [serial_port_regs_pkg::LVL_W-1:0] tx_empty_level_i,
    // Receive FIFO side
    output logic rx_pop_o,
    input wire logic [serial_port_regs_pkg::DATA_W-1:0] rx_data_i,
    input wire logic rx_empty_i,
    input wire logic rx_push_i,
    input wire logic rx_full_i,
    input wire logic [FIFO_LVL_W-1:0] rx_level_i,
    input wire logic [serial_port_regs_pkg::LVL_W-1:0] rx_full_level_i,
    // Serial pins
    input wire logic contention_i,
    input wire logic sclk_i,
    input wire logic rxd_i,
    output logic rx_sample_o,
    output logic rx_sample_valid_o,
    // DMA and interrupt
    output logic tx_dma_req_o,
    output logic rx_dma_req_o,
    output logic irq_o
);

    // ****************************************************
    // State and decode signals
    // ****************************************************
    serial_port_regs_pkg::regs_state_t s_reg;
    serial_port_regs_pkg::regs_state_t s_next;
    logic req;
    logic rd;
    logic wr;
    logic [7:0] adr;
    logic in_window;
    logic sclk_rise;
    logic [5:0] raw_flags;
    logic [5:0] events;
    logic [5:0] clears;
    logic [31:0] rd_data;

    // Accept one request per bus cycle; ack is held off for the next
    assign req = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    assign rd = req & ~wb_we_i;
    assign wr = req & wb_we_i;
    assign adr = {wb_adr_i[7:2], 2'h0};
    assign in_window = (adr >= serial_port_regs_pkg::OFF_DATA_LO)
        && (adr <= serial_port_regs_pkg::OFF_DATA_HI);
    assign sclk_rise = s_reg.sclk_sync[1] & ~s_reg.sclk_prev;

    // Raw flags: two live levels plus four sticky events
    always_comb begin
        raw_flags = s_reg.sticky & serial_port_regs_pkg::STICKY_MASK;
        raw_flags[serial_port_regs_pkg::BIT_TX_EMPTY] =
            ({{(32-FIFO_LVL_W){1'b0}}, tx_level_i}
            <= {29'h0, tx_empty_level_i});
        raw_flags[serial_port_regs_pkg::BIT_RX_FULL] =
            ({{(32-FIFO_LVL_W){1'b0}}, rx_level_i}
            >= {29'h0, rx_full_level_i});
    end

    // Hardware events that set sticky flags
    always_comb begin
        events = 6'h00;
        events[serial_port_regs_pkg::BIT_TX_OVF] = wr & in_window & wb_sel_i[0]
            & tx_full_i;
        events[serial_port_regs_pkg::BIT_RX_UND] = rd & in_window & rx_empty_i;
        events[serial_port_regs_pkg::BIT_RX_OVF] = rx_push_i & rx_full_i;
        events[serial_port_regs_pkg::BIT_CONT] = s_reg.cont_sync[1];
    end

    // Read-to-clear and write-one-to-clear sources
    always_comb begin
        clears = 6'h00;
        if (rd && adr == serial_port_regs_pkg::OFF_TXO_CLR) begin
            clears[serial_port_regs_pkg::BIT_TX_OVF] = 1'b1;
        end else if (rd && adr == serial_port_regs_pkg::OFF_RXO_CLR) begin
            clears[serial_port_regs_pkg::BIT_RX_OVF] = 1'b1;
        end else if (rd && adr == serial_port_regs_pkg::OFF_RXU_CLR) begin
            clears[serial_port_regs_pkg::BIT_RX_UND] = 1'b1;
        end else if (rd && adr == serial_port_regs_pkg::OFF_CONT_CLR) begin
            clears[serial_port_regs_pkg::BIT_CONT] = 1'b1;
        end else if (rd && adr == serial_port_regs_pkg::OFF_ALL_CLR) begin
            clears = serial_port_regs_pkg::STICKY_MASK;
        end else if (wr && adr == serial_port_regs_pkg::OFF_IRQ_CLR && wb_sel_i[0]) begin
            clears = wb_dat_i[5:0] & serial_port_regs_pkg::STICKY_MASK;
        end
    end

    // Read data multiplexer; read-to-clear registers return the flag they clear, clear-all the OR of all four
    always_comb begin
        rd_data = 32'h0000_0000;
        if (adr == serial_port_regs_pkg::OFF_IRQ_EN) begin
            rd_data[5:0] = s_reg.irq_en;
        end else if (adr == serial_port_regs_pkg::OFF_MASKED) begin
            rd_data[5:0] = raw_flags & s_reg.irq_en;
        end else if (adr == serial_port_regs_pkg::OFF_RAW) begin
            rd_data[5:0] = raw_flags;
        end else if (adr == serial_port_regs_pkg::OFF_TXO_CLR) begin
            rd_data[0] = raw_flags[serial_port_regs_pkg::BIT_TX_OVF];
        end else if (adr == serial_port_regs_pkg::OFF_RXO_CLR) begin
            rd_data[0] = raw_flags[serial_port_regs_pkg::BIT_RX_OVF];
        end else if (adr == serial_port_regs_pkg::OFF_RXU_CLR) begin
            rd_data[0] = raw_flags[serial_port_regs_pkg::BIT_RX_UND];
        end else if (adr == serial_port_regs_pkg::OFF_CONT_CLR) begin
            rd_data[0] = raw_flags[serial_port_regs_pkg::BIT_CONT];
        end else if (adr == serial_port_regs_pkg::OFF_ALL_CLR) begin
            rd_data[0] = |(raw_flags & serial_port_regs_pkg::STICKY_MASK);
        end else if (adr == serial_port_regs_pkg::OFF_DMA_GATE) begin
            rd_data[1:0] = s_reg.dma_gate;
        end else if (adr == serial_port_regs_pkg::OFF_TX_DMA_LVL) begin
            rd_data[2:0] = s_reg.tx_dma_lvl;
        end else if (adr == serial_port_regs_pkg::OFF_RX_DMA_LVL) begin
            rd_data[2:0] = s_reg.rx_dma_lvl;
        end else if (adr == serial_port_regs_pkg::OFF_IDENTITY) begin
            rd_data = IDENTITY_VALUE;
        end else if (adr == serial_port_regs_pkg::OFF_REVISION) begin
            rd_data = REVISION_VALUE;
        end else if (in_window) begin
            rd_data[15:0] = rx_empty_i ? 16'h0000 : rx_data_i;
        end else if (adr == serial_port_regs_pkg::OFF_SPARE_A) begin
            rd_data = s_reg.spare_a;
        end else if (adr == serial_port_regs_pkg::OFF_SPARE_B) begin
            rd_data = s_reg.spare_b;
        end else if (adr == serial_port_regs_pkg::OFF_SAMPLE_DLY) begin
            rd_data[7:0] = s_reg.dly;
        end
    end

    // Byte-lane merge for full-word writable registers
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    // ****************************************************
    // Next-state logic
    // ****************************************************
    always_comb begin
        s_next = s_reg;
        s_next.ack = req;
        s_next.push.valid = 1'b0;
        s_next.rx_pop = 1'b0;
        s_next.smp_valid = 1'b0;
        if (rd) begin
            s_next.dat = rd_data;
        end
        // Set wins over a clear in the same cycle so no event is lost
        s_next.sticky = ((s_reg.sticky & ~clears) | events)
            & serial_port_regs_pkg::STICKY_MASK;
        s_next.irq = |(raw_flags & s_reg.irq_en);
        // Levels are registered so the DMA request lines never glitch
        s_next.tx_dma_req = s_reg.dma_gate[serial_port_regs_pkg::BIT_TX_GATE]
            && ({{(32-FIFO_LVL_W){1'b0}}, tx_level_i}
            <= {29'h0, s_reg.tx_dma_lvl});
        s_next.rx_dma_req = s_reg.dma_gate[serial_port_regs_pkg::BIT_RX_GATE]
            && ({{(32-FIFO_LVL_W){1'b0}}, rx_level_i}
            > {29'h0, s_reg.rx_dma_lvl});
        // Register writes
        if (wr && wb_sel_i[0]) begin
            if (adr == serial_port_regs_pkg::OFF_IRQ_EN) begin
                s_next.irq_en = wb_dat_i[5:0];
            end else if (adr == serial_port_regs_pkg::OFF_DMA_GATE) begin
                s_next.dma_gate = wb_dat_i[1:0];
            end else if (adr == serial_port_regs_pkg::OFF_TX_DMA_LVL) begin
                s_next.tx_dma_lvl = wb_dat_i[2:0];
            end else if (adr == serial_port_regs_pkg::OFF_RX_DMA_LVL) begin
                s_next.rx_dma_lvl = wb_dat_i[2:0];
            end else if (adr == serial_port_regs_pkg::OFF_SAMPLE_DLY) begin
                s_next.dly = wb_dat_i[7:0];
            end
        end
        if (wr && adr == serial_port_regs_pkg::OFF_SPARE_A) begin
            s_next.spare_a = lane_merge(s_reg.spare_a, wb_dat_i, wb_sel_i);
        end
        if (wr && adr == serial_port_regs_pkg::OFF_SPARE_B) begin
            s_next.spare_b = lane_merge(s_reg.spare_b, wb_dat_i, wb_sel_i);
        end
        // Data window: a push into a full FIFO is dropped, not forwarded
        if (wr && in_window && wb_sel_i[0] && !tx_full_i) begin
            s_next.push.valid = 1'b1;
            s_next.push.data = wb_dat_i[15:0];
        end
        if (rd && in_window && !rx_empty_i) begin
            s_next.rx_pop = 1'b1;
        end
        // Pin synchronisers; only stage two is looked at
        s_next.sclk_sync = {s_reg.sclk_sync[0], sclk_i};
        s_next.sclk_prev = s_reg.sclk_sync[1];
        s_next.rxd_sync = {s_reg.rxd_sync[0], rxd_i};
        s_next.cont_sync = {s_reg.cont_sync[0], contention_i};
        // Sample delay: edges arriving during a wait are ignored
        case (s_reg.smp_st)
            serial_port_regs_pkg::smp_idle: begin
                if (sclk_rise) begin
                    if (s_reg.dly == 8'h00) begin
                        s_next.smp_bit = s_reg.rxd_sync[1];
                        s_next.smp_valid = 1'b1;
                    end else begin
                        s_next.smp_cnt = s_reg.dly;
                        s_next.smp_st = serial_port_regs_pkg::smp_wait;
                    end
                end
            end
            serial_port_regs_pkg::smp_wait: begin
                if (s_reg.smp_cnt == 8'h01) begin
                    s_next.smp_bit = s_reg.rxd_sync[1];
                    s_next.smp_valid = 1'b1;
                    s_next.smp_st = serial_port_regs_pkg::smp_idle;
                end else begin
                    s_next.smp_cnt = s_reg.smp_cnt - 8'h01;
                end
            end
            default: begin
                s_next.smp_st = serial_port_regs_pkg::smp_idle;
            end
        endcase
    end

    // ****************************************************
    // State register
    // ****************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.irq_en <= serial_port_regs_pkg::IRQ_EN_RST;
            s_reg.tx_dma_lvl <= serial_port_regs_pkg::LVL_RST;
            s_reg.rx_dma_lvl <= serial_port_regs_pkg::LVL_RST;
            s_reg.dly <= serial_port_regs_pkg::DLY_RST;
            s_reg.spare_a <= serial_port_regs_pkg::SPARE_RST;
            s_reg.spare_b <= serial_port_regs_pkg::SPARE_RST;
            s_reg.smp_st <= serial_port_regs_pkg::smp_idle;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from state
    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = s_reg.dat;
    assign tx_push_o = s_reg.push;
    assign rx_pop_o = s_reg.rx_pop;
    assign rx_sample_o = s_reg.smp_bit;
    assign rx_sample_valid_o = s_reg.smp_valid;
    assign tx_dma_req_o = s_reg.tx_dma_req;
    assign rx_dma_req_o = s_reg.rx_dma_req;
    assign irq_o = s_reg.irq;

    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_cont_sets;
        s_reg.cont_sync[1] |=> raw_flags[5] [*2];
    endproperty
    a_cont_sets: assert property (p_cont_sets)
        else $error("contention flag not held");

    property p_rx_full;
        (rx_level_i >= FIFO_LVL_W'(rx_full_level_i)) |-> raw_flags[4];
    endproperty
    a_rx_full: assert property (p_rx_full)
        else $error("rx full flag missing");

    property p_rx_ovf;
        rx_push_i && rx_full_i |=> raw_flags[3] && s_reg.sticky[3];
    endproperty
    a_rx_ovf: assert property (p_rx_ovf)
        else $error("rx overflow flag missing");

    property p_rx_und;
        rd && in_window && rx_empty_i |=> raw_flags[2] && !rx_pop_o && wb_ack_o;
    endproperty
    a_rx_und: assert property (p_rx_und)
        else $error("rx underflow flag missing");

    property p_tx_ovf;
        wr && in_window && wb_sel_i[0] && tx_full_i |=> raw_flags[1] && !tx_push_o.valid;
    endproperty
    a_tx_ovf: assert property (p_tx_ovf)
        else $error("tx overflow not flagged");

    property p_rxo_clear;
        rd && adr == serial_port_regs_pkg::OFF_RXO_CLR && !(rx_push_i && rx_full_i)
            |=> !raw_flags[3];
    endproperty
    a_rxo_clear: assert property (p_rxo_clear)
        else $error("rx overflow not cleared");

    property p_all_clear;
        rd && adr == serial_port_regs_pkg::OFF_ALL_CLR && !(rx_push_i && rx_full_i)
            && !s_reg.cont_sync[1] |=> raw_flags[3] == 1'b0 && raw_flags[1] == 1'b0;
    endproperty
    a_all_clear: assert property (p_all_clear)
        else $error("clear-all missed a flag");

    property p_tx_gate;
        !s_reg.dma_gate[1] |=> !tx_dma_req_o;
    endproperty
    a_tx_gate: assert property (p_tx_gate)
        else $error("tx dma request while gated");

    property p_delay;
        sclk_rise && s_reg.smp_st == serial_port_regs_pkg::smp_idle
            && s_reg.dly == 8'h03 |=> !rx_sample_valid_o [*3] ##1 rx_sample_valid_o;
    endproperty
    a_delay: assert property (p_delay)
        else $error("sample delay of three wrong");

    property p_irq;
        |(raw_flags & s_reg.irq_en) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq not raised");

    property p_write_push;
        wr && in_window && wb_sel_i[0] && !tx_full_i |=> tx_push_o.valid ##1 !tx_push_o.valid;
    endproperty
    a_write_push: assert property (p_write_push)
        else $error("push pulse wrong");

    c_push: cover property (tx_push_o.valid);
    c_pop: cover property (rx_pop_o);
    c_irq: cover property (irq_o);
    c_delay: cover property (s_reg.smp_st == serial_port_regs_pkg::smp_wait ##1 rx_sample_valid_o);

endmodule : serial_port_irq_dma_regs

`default_nettype wire

// File: bench/serial_far_end.sv
/*
 * Far-end model: transmit and receive FIFOs of eight words and the serial
 * peripheral that clocks words in. Assumes the bench drives frame_i and
 * inject_i off the rising edge of clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module serial_far_end (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Block side
    input wire serial_port_regs_pkg::tx_push_t tx_push_i,
    input wire logic rx_pop_i,
    output logic tx_full_o,
    output logic [3:0] tx_level_o,
    output logic [15:0] rx_data_o,
    output logic rx_empty_o,
    output logic rx_full_o,
    output logic [3:0] rx_level_o,
    output logic rx_push_o,
    // Serial side, steered by the bench
    input wire logic frame_i,
    input wire logic inject_i,
    input wire logic [15:0] inject_data_i,
    output logic sclk_o,
    output logic rxd_o
);
    logic [15:0] mem [8];
    logic [2:0] rd_ptr;
    logic [2:0] wr_ptr;
    logic [15:0] last;
    logic take;
    logic give;

    // A word that arrives while full is lost, yet still reported as pushed
    assign take = inject_i && !rx_full_o;
    assign give = rx_pop_i && !rx_empty_o;
    assign rx_push_o = inject_i;
    assign rx_empty_o = (rx_level_o == 4'h0);
    assign rx_full_o = (rx_level_o == 4'h8);
    assign tx_full_o = (tx_level_o == 4'h8);
    // An empty FIFO shows no stale head: the inverse of the last word
    assign rx_data_o = rx_empty_o ? ~last : mem[rd_ptr];

    // FIFO state; the transmitter drains one word a cycle only within frames
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_level_o <= 4'h0;
            tx_level_o <= 4'h0;
            rd_ptr <= 3'h0;
            wr_ptr <= 3'h0;
            last <= 16'h0;
            rxd_o <= 1'b0;
        end else begin
            if (take) begin
                mem[wr_ptr] <= inject_data_i;
                wr_ptr <= wr_ptr + 3'h1;
            end
            if (give) begin
                last <= mem[rd_ptr];
                rd_ptr <= rd_ptr + 3'h1;
            end
            rx_level_o <= rx_level_o + 4'(take) - 4'(give);
            tx_level_o <= tx_level_o + 4'(tx_push_i.valid && !tx_full_o)
                - 4'(frame_i && tx_level_o != 4'h0);
            // Data line idles with a toggling pattern, steady high in frames
            rxd_o <= frame_i | ~rxd_o;
        end
    end

    // Link clock of 200 ns, standing low outside frames
    always begin
        #100;
        sclk_o = frame_i ? ~sclk_o : 1'b0;
    end
endmodule : serial_far_end

`default_nettype wire

// File: bench/serial_port_irq_dma_regs_tb_top.sv
/*
 * Self-checking bench for the interrupt, DMA and data-window registers.
 * Assumes the far-end model serial_far_end beside the block.
 */
`timescale 1ns/1ps
`default_nettype none

module serial_port_irq_dma_regs_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic frame = 1'b0;
    logic inject = 1'b0;
    logic [15:0] inject_data = 16'h0;
    logic contention = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, tx_full, rx_empty, rx_full, rx_push, sclk, rxd, rx_pop_o;
    logic rx_sample_o, rx_sample_valid_o, tx_dma_req_o, rx_dma_req_o, irq_o;
    logic [3:0] tx_level, rx_level;
    logic [15:0] rx_data;
    serial_port_regs_pkg::tx_push_t tx_push_o;
    logic [31:0] rdq[$];
    logic [15:0] pushq[$];
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] rst_adr [7] = '{8'h34, 8'h4c, 8'h50, 8'h54, 8'hfc, 8'hf4, 8'h10};

    // System clock, 25 ns period
    always #12.5 clk_i = ~clk_i;

    serial_port_irq_dma_regs u_serial_port_irq_dma_regs (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_push_o(tx_push_o),
        .tx_full_i(tx_full), .tx_level_i(tx_level), .tx_empty_level_i(3'h1),
        .rx_pop_o(rx_pop_o), .rx_data_i(rx_data), .rx_empty_i(rx_empty),
        .rx_push_i(rx_push), .rx_full_i(rx_full), .rx_level_i(rx_level),
        .rx_full_level_i(3'h4), .contention_i(contention), .sclk_i(sclk), .rxd_i(rxd),
        .rx_sample_o(rx_sample_o), .rx_sample_valid_o(rx_sample_valid_o),
        .tx_dma_req_o(tx_dma_req_o), .rx_dma_req_o(rx_dma_req_o), .irq_o(irq_o));

    serial_far_end u_serial_far_end (
        .clk_i(clk_i), .rst_i(rst_i), .tx_push_i(tx_push_o), .rx_pop_i(rx_pop_o),
        .tx_full_o(tx_full), .tx_level_o(tx_level), .rx_data_o(rx_data),
        .rx_empty_o(rx_empty), .rx_full_o(rx_full), .rx_level_o(rx_level),
        .rx_push_o(rx_push), .frame_i(frame), .inject_i(inject),
        .inject_data_i(inject_data), .sclk_o(sclk), .rxd_o(rxd));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("comparisons %0d, err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    // Classic cycle; on a read d is the expected answer
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d);
        if (!we) rdq.push_back(d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    // Cycles from the second link edge of a frame to the sample pulse
    task automatic measure(output int gap);
        frame <= 1'b1;
        repeat (2) @(posedge sclk);
        @(posedge clk_i);
        gap = 0;
        while (rx_sample_valid_o !== 1'b1 && gap < 40) begin
            @(posedge clk_i);
            gap++;
        end
        check("sampled bit", rx_sample_o, 32'h1);
        frame <= 1'b0;
        @(posedge clk_i);
    endtask : measure

    // Scoreboard: each answer or push takes the oldest note
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we === 1'b0) begin
            check("read data", wb_dat_o, rdq.pop_front());
        end
        if (tx_push_o.valid === 1'b1) begin
            check("push data", {16'h0, tx_push_o.data}, {16'h0, pushq.pop_front()});
        end
    end

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            conclude();
        end
    end

    initial begin
        logic [31:0] v;
        logic [15:0] words [8];
        int gap [2];
        v = 32'h0994ae7e;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Reset values; only the live empty level is high, holes read zero
        foreach (rst_adr[i]) bus(1'b0, rst_adr[i], {31'h0, i == 0});
        bus(1'b1, 8'h2c, 32'h2);
        bus(1'b1, 8'h4c, 32'h3);
        bus(1'b1, 8'h50, 32'h2);
        bus(1'b1, 8'h54, 32'h0);
        bus(1'b0, 8'h4c, 32'h3);
        repeat (3) @(posedge clk_i);
        check("tx dma", tx_dma_req_o, 32'h1);
        check("rx dma", rx_dma_req_o, 32'h0);
        // Fill the transmit side, the ninth word overflows
        for (int i = 0; i < 9; i++) begin
            v = lfsr(v);
            if (i < 8) pushq.push_back(v[15:0]);
            bus(1'b1, i[0] ? 8'h9c : 8'h60, v);
        end
        repeat (2) @(posedge clk_i);
        check("irq", irq_o, 32'h1);
        check("tx dma", tx_dma_req_o, 32'h0);
        bus(1'b0, 8'h30, 32'h2);
        bus(1'b0, 8'h38, 32'h1);
        bus(1'b0, 8'h38, 32'h0);
        repeat (2) @(posedge clk_i);
        check("irq", irq_o, 32'h0);
        // Fill the receive side, the ninth word overflows
        for (int i = 0; i < 9; i++) begin
            v = lfsr(v);
            if (i < 8) words[i] = v[15:0];
            inject_data <= v[15:0];
            inject <= 1'b1;
            @(posedge clk_i);
            inject <= 1'b0;
            @(posedge clk_i);
        end
        repeat (3) @(posedge clk_i);
        check("rx dma", rx_dma_req_o, 32'h1);
        bus(1'b0, 8'h34, 32'h18);
        bus(1'b0, 8'h3c, 32'h1);
        bus(1'b0, 8'h34, 32'h10);
        for (int i = 0; i < 8; i++) bus(1'b0, 8'h60 + 8'(i * 4), {16'h0, words[i]});
        bus(1'b0, 8'h60, 32'h0);
        bus(1'b0, 8'h34, 32'h4);
        bus(1'b0, 8'h40, 32'h1);
        bus(1'b0, 8'h34, 32'h0);
        // Contention, cleared alone and then with everything else
        for (int k = 0; k < 2; k++) begin
            contention <= 1'b1;
            repeat (4) @(posedge clk_i);
            contention <= 1'b0;
            repeat (4) @(posedge clk_i);
            bus(1'b0, 8'h60, 32'h0);
            bus(1'b0, 8'h34, 32'h24);
            bus(1'b0, k ? 8'h48 : 8'h44, 32'h1);
            bus(1'b0, 8'h34, k ? 32'h0 : 32'h4);
            bus(1'b0, 8'h40, 32'(1 - k));
        end
        // Sample delay of three adds exactly three cycles
        measure(gap[0]);
        bus(1'b1, 8'hfc, 32'h3);
        bus(1'b0, 8'hfc, 32'h3);
        measure(gap[1]);
        check("sample delay", 32'(gap[1] - gap[0]), 32'h3);
        conclude();
    end
endmodule : serial_port_irq_dma_regs_tb_top

`default_nettype wire
